// ==== hdl/cbp_if.sv ====
/*
  frame link between reader and tag: one byte per valid cycle, start and end
  of frame flagged on the first and last byte, plus an activation pulse.
  assumes both ends share clk_sys; the link is half duplex.
*/
`timescale 1ns/1ps
interface cbp_if;
  logic       activate;
  logic       r2tValid;
  logic [7:0] r2tData;
  logic       r2tSof;
  logic       r2tEof;
  logic       t2rValid;
  logic [7:0] t2rData;
  logic       t2rSof;
  logic       t2rEof;

  modport tag (
    input  activate,
    input  r2tValid,
    input  r2tData,
    input  r2tSof,
    input  r2tEof,
    output t2rValid,
    output t2rData,
    output t2rSof,
    output t2rEof
  );

  modport reader (
    output activate,
    output r2tValid,
    output r2tData,
    output r2tSof,
    output r2tEof,
    input  t2rValid,
    input  t2rData,
    input  t2rSof,
    input  t2rEof
  );
endinterface

// ==== hdl/cbp_pkg.sv ====
/*
  shared constants, block header coding and CRC_B step for both link ends.
  assumes one clock for both ends and a byte-wide frame stream between them.
*/
package cbp_pkg;
  localparam int FRAME_MAX = 256;
  localparam int INF_MAX   = 253;
  localparam int CHAIN_MIN = 64;
  localparam int ECD_LEN   = 2;
  // smallest information field of a chained block: frame less header and crc
  localparam int CHAIN_MIN_INF = CHAIN_MIN - 1 - ECD_LEN;

  localparam int BIT_BN    = 0;
  localparam int BIT_NAD   = 2;
  localparam int BIT_CID   = 3;
  localparam int BIT_CHAIN = 4;
  localparam int BIT_NAK   = 4;

  localparam logic [7:0] PCB_I     = 8'h02;
  localparam logic [7:0] PCB_R     = 8'ha2;
  localparam logic [7:0] PCB_DESEL = 8'hc2;
  localparam logic [7:0] PCB_WTX   = 8'hf2;
  localparam logic [7:0] MASK_FLAG = 8'h10;

  localparam logic [1:0] TYPE_I = 2'b00;
  localparam logic [1:0] TYPE_R = 2'b10;
  localparam logic [1:0] TYPE_S = 2'b11;

  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'h8408;
  localparam logic [15:0] CRC_GOOD = 16'hf0b8;

  typedef enum logic [2:0] {
    CMD_I      = 3'h0,
    CMD_ICHAIN = 3'h1,
    CMD_ACK    = 3'h2,
    CMD_NAK    = 3'h3,
    CMD_DESEL  = 3'h4
  } cmd_t;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] x;
    x = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      x = x[0] ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
    end
    return x;
  endfunction

  function automatic logic [1:0] blk_type(input logic [7:0] pcb);
    return pcb[7:6];
  endfunction

  function automatic logic [7:0] with_bn(input logic [7:0] base, input logic bn);
    return {base[7:1], bn};
  endfunction
endpackage

// ==== hdl/reader_end.sv ====
/*
  reader end of the block protocol: builds command blocks with header and
  crc, streams their data from the user, checks replies, keeps its number.
  assumes the tag end on the cbp_if link; one block in flight at a time.
*/
`timescale 1ns/1ps
module reader_end
  import cbp_pkg::*;
#(
  parameter int INF_MAX_P = INF_MAX
) (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  cbp_if.reader           lnk,
  input  wire logic       actGo,
  input  wire logic       cmdGo,
  input  wire cmd_t       cmdKind,
  output logic            cmdReady,
  input  wire logic       datValid,
  input  wire logic [7:0] datData,
  input  wire logic       datLast,
  output logic            datReady,
  output logic            rspValid,
  output logic [7:0]      rspData,
  output logic            rspEnd,
  output logic            rspGood,
  output logic [7:0]      rspPcb
);
  typedef enum logic [4:0] {
    R_IDLE = 5'b00001,
    R_HEAD = 5'b00010,
    R_DATA = 5'b00100,
    R_CRC0 = 5'b01000,
    R_CRC1 = 5'b10000
  } state_t;

  typedef struct packed {
    state_t          state;
    logic            bn;
    logic            isI;
    logic            chain;
    logic [7:0]      txPcb;
    logic [7:0]      txCnt;
    logic [15:0]     txCrc;
    logic            act;
    logic            oValid;
    logic [7:0]      oData;
    logic            oSof;
    logic            oEof;
    logic            inFrame;
    logic            bad;
    logic [8:0]      rxCnt;
    logic [15:0]     rxCrc;
    logic [1:0][7:0] hold;
    logic            rspValid;
    logic [7:0]      rspData;
    logic            rspEnd;
    logic            rspGood;
    logic [7:0]      rspPcb;
  } st_t;

  st_t s_r;
  st_t s_nxt;

  always_comb begin
    logic [15:0] crcNxt;
    logic        ok;
    logic [7:0]  pcb;
    crcNxt = CRC_INIT;
    ok     = 1'b0;
    pcb    = 8'h00;
    s_nxt  = s_r;
    s_nxt.act      = actGo;
    s_nxt.oValid   = 1'b0;
    s_nxt.oSof     = 1'b0;
    s_nxt.oEof     = 1'b0;
    s_nxt.rspValid = 1'b0;
    s_nxt.rspEnd   = 1'b0;

    case (s_r.state)
      R_IDLE: begin
        if (cmdGo) begin
          s_nxt.state = R_HEAD;
          s_nxt.isI   = cmdKind == CMD_I || cmdKind == CMD_ICHAIN;
          s_nxt.chain = cmdKind == CMD_ICHAIN;
          s_nxt.txCnt = 8'h00;
          s_nxt.txCrc = CRC_INIT;
          case (cmdKind)
            CMD_I:      s_nxt.txPcb = with_bn(PCB_I, s_r.bn);
            CMD_ICHAIN: s_nxt.txPcb = with_bn(PCB_I | MASK_FLAG, s_r.bn);
            CMD_ACK:    s_nxt.txPcb = with_bn(PCB_R, s_r.bn);
            CMD_NAK:    s_nxt.txPcb = with_bn(PCB_R | MASK_FLAG, s_r.bn);
            default:    s_nxt.txPcb = PCB_DESEL;
          endcase
        end
      end
      R_HEAD: begin
        s_nxt.oValid = 1'b1;
        s_nxt.oSof   = 1'b1;
        s_nxt.oData  = s_r.txPcb;
        s_nxt.txCrc  = crc_step(s_r.txCrc, s_r.txPcb);
        s_nxt.state  = s_r.isI ? R_DATA : R_CRC0;
      end
      R_DATA: begin
        if (datValid) begin
          s_nxt.oValid = 1'b1;
          s_nxt.oData  = datData;
          s_nxt.txCrc  = crc_step(s_r.txCrc, datData);
          s_nxt.txCnt  = s_r.txCnt + 8'd1;
          // a chained block is held open until it reaches the least frame
          if ((datLast && (!s_r.chain || s_nxt.txCnt >= 8'(CHAIN_MIN_INF)))
              || s_nxt.txCnt >= 8'(INF_MAX_P)) begin
            s_nxt.state = R_CRC0;
          end
        end
      end
      R_CRC0: begin
        s_nxt.oValid = 1'b1;
        s_nxt.oData  = ~s_r.txCrc[7:0];
        s_nxt.state  = R_CRC1;
      end
      R_CRC1: begin
        s_nxt.oValid = 1'b1;
        s_nxt.oData  = ~s_r.txCrc[15:8];
        s_nxt.oEof   = 1'b1;
        s_nxt.state  = R_IDLE;
      end
      default: s_nxt.state = R_IDLE;
    endcase

    if (lnk.t2rValid) begin
      crcNxt = crc_step(lnk.t2rSof ? CRC_INIT : s_r.rxCrc, lnk.t2rData);
      s_nxt.rxCrc = crcNxt;
      if (lnk.t2rSof) begin
        s_nxt.inFrame = 1'b1;
        s_nxt.rxCnt   = 9'd1;
        s_nxt.rspPcb  = lnk.t2rData;
        s_nxt.bad     = 1'b0;
      end else if (s_r.inFrame) begin
        if (s_r.rxCnt >= 9'(FRAME_MAX)) begin
          s_nxt.bad = 1'b1;
        end else begin
          s_nxt.rxCnt = s_r.rxCnt + 9'd1;
        end
        s_nxt.hold = {s_r.hold[0], lnk.t2rData};
        if (s_r.rxCnt >= 9'd3) begin
          s_nxt.rspValid = 1'b1;
          s_nxt.rspData  = s_r.hold[1];
        end
      end
      if (lnk.t2rEof && (lnk.t2rSof || s_r.inFrame)) begin
        s_nxt.inFrame = 1'b0;
        pcb = s_nxt.rspPcb;
        ok  = !s_nxt.bad && crcNxt == CRC_GOOD && s_nxt.rxCnt >= 9'd3;
        s_nxt.rspEnd  = 1'b1;
        s_nxt.rspGood = ok;
        if (ok && pcb[BIT_BN] == s_r.bn && (blk_type(pcb) == TYPE_I
            || (blk_type(pcb) == TYPE_R && !pcb[BIT_NAK]))) begin
          s_nxt.bn = ~s_r.bn;
        end
      end
    end

    if (actGo) begin
      s_nxt.bn      = 1'b0;
      s_nxt.inFrame = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_r       <= '0;
      s_r.state <= R_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign lnk.activate = s_r.act;
  assign lnk.r2tValid = s_r.oValid;
  assign lnk.r2tData  = s_r.oData;
  assign lnk.r2tSof   = s_r.oSof;
  assign lnk.r2tEof   = s_r.oEof;
  assign cmdReady     = s_r.state == R_IDLE;
  assign datReady     = s_r.state == R_DATA;
  assign rspValid     = s_r.rspValid;
  assign rspData      = s_r.rspData;
  assign rspEnd       = s_r.rspEnd;
  assign rspGood      = s_r.rspGood;
  assign rspPcb       = s_r.rspPcb;
endmodule

// ==== hdl/tag_end.sv ====
/*
  tag end of the block protocol: checks and parses received blocks, keeps
  the block number, answers with I, R or S blocks and keeps the last
  I-block for retransmission.
  assumes the reader end on the cbp_if link and an application that fills
  the reply buffer while appTurn is high.
*/
`timescale 1ns/1ps
module tag_end
  import cbp_pkg::*;
#(
  parameter int INF_MAX_P = INF_MAX
) (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  cbp_if.tag              lnk,
  output logic            infValid,
  output logic [7:0]      infData,
  output logic            infEnd,
  output logic            infGood,
  output logic            appTurn,
  input  wire logic       txWrValid,
  input  wire logic [7:0] txWrData,
  input  wire logic       txGo,
  input  wire logic       txChain,
  output logic            deselected
);
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_APP  = 4'b0010,
    S_TX   = 4'b0100,
    S_OFF  = 4'b1000
  } state_t;

  typedef struct packed {
    state_t                    state;
    logic                      bn;
    logic                      chaining;
    logic                      haveI;
    logic                      offAfter;
    logic                      inFrame;
    logic                      bad;
    logic [8:0]                rxCnt;
    logic [15:0]               rxCrc;
    logic [7:0]                rxPcb;
    logic [1:0][7:0]           hold;
    logic                      infValid;
    logic [7:0]                infData;
    logic                      infEnd;
    logic                      infGood;
    logic [INF_MAX_P-1:0][7:0] buffer;
    logic [7:0]                bufLen;
    logic [7:0]                wrIdx;
    logic [7:0]                lastPcb;
    logic [7:0]                txPcb;
    logic                      useBuf;
    logic [8:0]                txIdx;
    logic [15:0]               txCrc;
    logic                      oValid;
    logic [7:0]                oData;
    logic                      oSof;
    logic                      oEof;
  } st_t;

  st_t s_r;
  st_t s_nxt;

  always_comb begin
    logic        go;
    logic [7:0]  goPcb;
    logic        goBuf;
    logic        ok;
    logic [7:0]  pcb;
    logic [15:0] crcNxt;
    logic [8:0]  dlen;
    logic [7:0]  b;
    go     = 1'b0;
    goPcb  = PCB_R;
    goBuf  = 1'b0;
    ok     = 1'b0;
    pcb    = 8'h00;
    crcNxt = CRC_INIT;
    dlen   = 9'd0;
    b      = 8'h00;
    s_nxt  = s_r;
    s_nxt.infValid = 1'b0;
    s_nxt.infEnd   = 1'b0;
    s_nxt.oValid   = 1'b0;
    s_nxt.oSof     = 1'b0;
    s_nxt.oEof     = 1'b0;

    // application fills the reply while it holds the turn
    if (s_r.state == S_APP) begin
      if (txWrValid && s_r.wrIdx < 8'(INF_MAX_P)) begin
        s_nxt.buffer[s_r.wrIdx] = txWrData;
        s_nxt.wrIdx = s_r.wrIdx + 8'd1;
      end
      if (txGo && (!txChain || s_nxt.wrIdx >= 8'(CHAIN_MIN_INF))) begin
        s_nxt.bufLen   = s_nxt.wrIdx;
        s_nxt.wrIdx    = 8'h00;
        s_nxt.lastPcb  = with_bn(txChain ? (PCB_I | MASK_FLAG) : PCB_I, s_r.bn);
        s_nxt.haveI    = 1'b1;
        s_nxt.chaining = txChain;
        go    = 1'b1;
        goPcb = s_nxt.lastPcb;
        goBuf = 1'b1;
      end
    end

    // receive path, ignored while the tag itself talks
    if (lnk.r2tValid && s_r.state != S_TX) begin
      crcNxt = crc_step(lnk.r2tSof ? CRC_INIT : s_r.rxCrc, lnk.r2tData);
      s_nxt.rxCrc = crcNxt;
      if (lnk.r2tSof) begin
        s_nxt.inFrame = 1'b1;
        s_nxt.rxCnt   = 9'd1;
        s_nxt.rxPcb   = lnk.r2tData;
        s_nxt.bad     = lnk.r2tData[BIT_CID] | lnk.r2tData[BIT_NAD];
      end else if (s_r.inFrame) begin
        if (s_r.rxCnt >= 9'(FRAME_MAX)) begin
          s_nxt.bad = 1'b1;
        end else begin
          s_nxt.rxCnt = s_r.rxCnt + 9'd1;
        end
        s_nxt.hold = {s_r.hold[0], lnk.r2tData};
        // the last two bytes are the crc, so data leaves two bytes late
        if (s_r.rxCnt >= 9'd3 && blk_type(s_r.rxPcb) == TYPE_I && s_r.state != S_OFF) begin
          s_nxt.infValid = 1'b1;
          s_nxt.infData  = s_r.hold[1];
        end
      end
      if (lnk.r2tEof && (lnk.r2tSof || s_r.inFrame)) begin
        s_nxt.inFrame = 1'b0;
        pcb = s_nxt.rxPcb;
        ok  = !s_nxt.bad && crcNxt == CRC_GOOD && s_nxt.rxCnt >= 9'd3;
        if (blk_type(pcb) == TYPE_I) begin
          s_nxt.infEnd  = 1'b1;
          s_nxt.infGood = ok && s_r.state != S_OFF;
        end
        if (ok && s_r.state != S_OFF) begin
          case (blk_type(pcb))
            TYPE_I: begin
              s_nxt.bn       = ~s_r.bn;
              s_nxt.chaining = 1'b0;
              if (pcb[BIT_CHAIN]) begin
                go    = 1'b1;
                goPcb = with_bn(PCB_R, ~s_r.bn);
              end else begin
                s_nxt.state = S_APP;
              end
            end
            TYPE_R: begin
              if (pcb[BIT_BN] == s_r.bn) begin
                if (s_r.haveI) begin
                  go    = 1'b1;
                  goPcb = s_r.lastPcb;
                  goBuf = 1'b1;
                end
              end else if (pcb[BIT_NAK]) begin
                go    = 1'b1;
                goPcb = with_bn(PCB_R, s_r.bn);
              end else begin
                s_nxt.bn = ~s_r.bn;
                if (s_r.chaining) begin
                  s_nxt.state = S_APP;
                end
              end
            end
            TYPE_S: begin
              if (pcb == PCB_DESEL) begin
                go    = 1'b1;
                goPcb = PCB_DESEL;
              end
            end
            default: begin
            end
          endcase
        end
      end
    end

    // only I, R and deselect headers are ever loaded here
    if (go) begin
      s_nxt.state    = S_TX;
      s_nxt.txPcb    = goPcb;
      s_nxt.useBuf   = goBuf;
      s_nxt.offAfter = goPcb == PCB_DESEL;
      s_nxt.txIdx    = 9'd0;
      s_nxt.txCrc    = CRC_INIT;
    end

    // transmit: header, buffered data, crc low then high
    if (s_r.state == S_TX) begin
      dlen = s_r.useBuf ? {1'b0, s_r.bufLen} : 9'd0;
      if (s_r.txIdx == 9'd0) begin
        b = s_r.txPcb;
      end else if (s_r.txIdx <= dlen) begin
        b = s_r.buffer[8'(s_r.txIdx - 9'd1)];
      end else if (s_r.txIdx == dlen + 9'd1) begin
        b = ~s_r.txCrc[7:0];
      end else begin
        b = ~s_r.txCrc[15:8];
      end
      if (s_r.txIdx <= dlen) begin
        s_nxt.txCrc = crc_step(s_r.txCrc, b);
      end
      s_nxt.oValid = 1'b1;
      s_nxt.oData  = b;
      s_nxt.oSof   = s_r.txIdx == 9'd0;
      s_nxt.oEof   = s_r.txIdx == dlen + 9'd2;
      s_nxt.txIdx  = s_r.txIdx + 9'd1;
      if (s_nxt.oEof) begin
        s_nxt.state = s_r.offAfter ? S_OFF : S_IDLE;
      end
    end

    if (lnk.activate) begin
      s_nxt.state    = S_IDLE;
      s_nxt.bn       = 1'b1;
      s_nxt.haveI    = 1'b0;
      s_nxt.chaining = 1'b0;
      s_nxt.inFrame  = 1'b0;
      s_nxt.wrIdx    = 8'h00;
      s_nxt.oValid   = 1'b0;
      s_nxt.oEof     = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_r       <= '0;
      s_r.state <= S_IDLE;
      s_r.bn    <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign lnk.t2rValid = s_r.oValid;
  assign lnk.t2rData  = s_r.oData;
  assign lnk.t2rSof   = s_r.oSof;
  assign lnk.t2rEof   = s_r.oEof;
  assign infValid     = s_r.infValid;
  assign infData      = s_r.infData;
  assign infEnd       = s_r.infEnd;
  assign infGood      = s_r.infGood;
  assign appTurn      = s_r.state == S_APP;
  assign deselected   = s_r.state == S_OFF;
endmodule

// ==== tb/cbp_monitor.sv ====
/*
  link monitor: assertions on the frame link between the reader and tag ends.
  assumes plain link signals, one clock clk_sys and a synchronous active low rst_n.
*/
`timescale 1ns/1ps
module cbp_monitor
  import cbp_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic       activate,
  input wire logic       r2tValid,
  input wire logic [7:0] r2tData,
  input wire logic       r2tSof,
  input wire logic       r2tEof,
  input wire logic       t2rValid,
  input wire logic [7:0] t2rData,
  input wire logic       t2rSof,
  input wire logic       t2rEof
);
  logic [8:0] tCnt_r;
  logic [8:0] rCnt_r;
  logic [7:0] lastHdr_r;
  logic       tagBn_r;
  logic       fresh_r;

  // byte counts of open frames, last reader header, tag's own number
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tCnt_r    <= 9'h000;
      rCnt_r    <= 9'h000;
      lastHdr_r <= 8'h00;
      tagBn_r   <= 1'b1;
      fresh_r   <= 1'b1;
    end else begin
      if (t2rValid) tCnt_r <= t2rSof ? 9'h001 : tCnt_r + 9'h001;
      if (r2tValid) rCnt_r <= r2tSof ? 9'h001 : rCnt_r + 9'h001;
      if (r2tValid && r2tSof) lastHdr_r <= r2tData;
      if (activate) tagBn_r <= 1'b1;
      else if (r2tValid && r2tSof && (r2tData[7:6] == TYPE_I || (r2tData[7:6] == TYPE_R
               && !r2tData[BIT_NAK] && r2tData[0] != tagBn_r))) tagBn_r <= ~tagBn_r;
      if (activate) fresh_r <= 1'b1;
      else if (r2tValid && r2tSof) fresh_r <= 1'b0;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence tagHead;
    t2rValid && t2rSof;
  endsequence
  sequence rHead;
    t2rValid && t2rSof && !t2rEof && t2rData[7:6] == TYPE_R;
  endsequence
  sequence rTail;
    (t2rValid && !t2rEof) ##1 (t2rValid && t2rEof);
  endsequence

  tag_frame_len_a: assert property (t2rValid && t2rEof && !t2rSof |->
    tCnt_r >= 9'h002 && tCnt_r <= 9'h0ff) else $error("tag frame length out of range");
  tag_gapless_a: assert property (t2rValid && !t2rEof |=> t2rValid)
    else $error("tag frame has a gap");
  rdr_frame_len_a: assert property (r2tValid && r2tEof && !r2tSof |->
    rCnt_r >= 9'h002 && rCnt_r <= 9'h0ff) else $error("reader frame length out of range");
  no_cid_nad_a: assert property (r2tValid && r2tSof |-> r2tData[3:2] == 2'b00)
    else $error("reader header carries cid or nad");
  no_wtx_a: assert property (tagHead |-> t2rData[7:6] != TYPE_S || t2rData == PCB_DESEL)
    else $error("tag sent a wait extension block");
  rblk_empty_a: assert property (rHead |=> rTail)
    else $error("tag ack block carries data");
  i_reply_bn_a: assert property (tagHead ##0 t2rData[7:6] == TYPE_I &&
    lastHdr_r[7:6] == TYPE_I |-> t2rData[0] == lastHdr_r[0]) else $error("reply number wrong");
  chain_ack_a: assert property (tagHead ##0 lastHdr_r[7:6] == TYPE_I &&
    lastHdr_r[BIT_CHAIN] |-> t2rData == {PCB_R[7:1], lastHdr_r[0]}) else $error("no chain ack");
  ack_time_a: assert property (r2tValid && r2tEof && lastHdr_r[7:6] == TYPE_I &&
    lastHdr_r[BIT_CHAIN] |-> ##2 (t2rValid && t2rSof)) else $error("chain ack late");
  nak_other_a: assert property (tagHead ##0 lastHdr_r[7:6] == TYPE_R &&
    lastHdr_r[BIT_NAK] && lastHdr_r[0] != tagBn_r |-> t2rData == {PCB_R[7:1], tagBn_r})
    else $error("nak not answered by ack");
  desel_reply_a: assert property (tagHead ##0 lastHdr_r == PCB_DESEL |->
    t2rData == PCB_DESEL) else $error("deselect not answered");
  rdr_start_bn_a: assert property (r2tValid && r2tSof && fresh_r &&
    r2tData[7:6] != TYPE_S |-> r2tData[0] == 1'b0) else $error("reader number not zero");
endmodule

// ==== tb/contactless_block_protocol_tb.sv ====
/*
  testbench: reader and tag ends joined on cbp_if, driven from their user sides.
  assumes the hand-over timing of both ends; inputs move 1 ns after the rising edge.
*/
`timescale 1ns/1ps
module contactless_block_protocol_tb
  import cbp_pkg::*;
;
  logic       clk_sys, rst_n, actGo, cmdGo, cmdReady, datValid, datLast, datReady;
  logic       infValid, infEnd, infGood, appTurn, deselected, txWrValid, txGo, txChain;
  logic       rspValid, rspEnd, rspGood, rspHit, rspOk, infOk;
  logic [7:0] infData, txWrData, datData, rspData, rspPcb;
  cmd_t       cmdKind;
  int         fail_count, comparisons;
  logic [7:0] rxQ[$];
  logic [7:0] rsQ[$];

  cbp_if lnk();
  tag_end tag_end_inst (.clk_sys, .rst_n, .lnk(lnk), .infValid, .infData, .infEnd,
    .infGood, .appTurn, .txWrValid, .txWrData, .txGo, .txChain, .deselected);
  reader_end reader_end_inst (.clk_sys, .rst_n, .lnk(lnk), .actGo, .cmdGo, .cmdKind,
    .cmdReady, .datValid, .datData, .datLast, .datReady, .rspValid, .rspData, .rspEnd,
    .rspGood, .rspPcb);
  cbp_monitor cbp_monitor_inst (.clk_sys, .rst_n, .activate(lnk.activate),
    .r2tValid(lnk.r2tValid), .r2tData(lnk.r2tData), .r2tSof(lnk.r2tSof),
    .r2tEof(lnk.r2tEof), .t2rValid(lnk.t2rValid), .t2rData(lnk.t2rData),
    .t2rSof(lnk.t2rSof), .t2rEof(lnk.t2rEof));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // collect user-side outputs away from the active edge
  always @(negedge clk_sys) begin
    if (infValid === 1'b1) rxQ.push_back(infData);
    if (rspValid === 1'b1) rsQ.push_back(rspData);
    if (infEnd === 1'b1) infOk = infGood;
    if (rspEnd === 1'b1) begin
      rspHit = 1'b1;
      rspOk = rspGood;
    end
  end

  task complete_run;
    $display("mismatches %0d comparisons %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task tick;
    @(posedge clk_sys);
    #1;
  endtask

  task hang;
    fail_count++;
    $display("unexpected at %0t: wait ran out", $time);
    complete_run;
  endtask

  task chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task rdCmd(input cmd_t k, input int n, input logic [7:0] b);
    int w;
    rsQ.delete();
    rxQ.delete();
    rspHit = 1'b0;
    infOk = 1'b0;
    w = 0;
    while (cmdReady !== 1'b1) begin
      tick;
      w++;
      if (w > 200) hang;
    end
    cmdGo = 1'b1;
    cmdKind = k;
    tick;
    cmdGo = 1'b0;
    for (int i = 0; i < n; i++) begin
      datValid = 1'b1;
      datData = 8'(i * 7) + b;
      datLast = (i == n - 1);
      w = 0;
      while (datReady !== 1'b1) begin
        tick;
        w++;
        if (w > 200) hang;
      end
      tick;
    end
    datValid = 1'b0;
    datLast = 1'b0;
  endtask

  task tagReply(input int n, input logic ch, input logic [7:0] b);
    int w;
    w = 0;
    while (appTurn !== 1'b1) begin
      tick;
      w++;
      if (w > 2000) hang;
    end
    for (int i = 0; i < n; i++) begin
      txWrValid = 1'b1;
      txWrData = 8'(i * 5) + b;
      tick;
    end
    txWrValid = 1'b0;
    txChain = ch;
    txGo = 1'b1;
    tick;
    txGo = 1'b0;
    txChain = 1'b0;
  endtask

  task waitRsp(input logic [7:0] p, input int n, input logic [7:0] b);
    int w;
    w = 0;
    while (rspHit !== 1'b1) begin
      tick;
      w++;
      if (w > 2000) hang;
    end
    tick;
    chk(16'(rspOk), 16'h0001, "reply check");
    chk(16'(rspPcb), 16'(p), "reply header");
    chk(16'(rsQ.size()), 16'(n), "reply length");
    for (int i = 0; i < n && i < rsQ.size(); i++) begin
      chk(16'(rsQ[i]), 16'(8'(8'(i * 5) + b)), "reply data");
    end
  endtask

  task expInf(input int n, input logic [7:0] b);
    chk(16'(infOk), 16'h0001, "tag block check");
    chk(16'(rxQ.size()), 16'(n), "tag data length");
    for (int i = 0; i < n && i < rxQ.size(); i++) begin
      chk(16'(rxQ[i]), 16'(8'(8'(i * 7) + b)), "tag data");
    end
  endtask

  task act;
    actGo = 1'b1;
    tick;
    actGo = 1'b0;
    tick;
  endtask

  initial begin
    {rst_n, actGo, cmdGo, datValid, datLast, txWrValid, txGo, txChain} = 8'h00;
    {datData, txWrData, rspHit, rspOk, infOk} = 19'h00000;
    {fail_count, comparisons} = 64'h0;
    cmdKind = CMD_I;
    repeat (2) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    tick;
    chk(16'({appTurn, deselected}), 16'h0000, "idle after reset");
    act;
    rdCmd(CMD_I, 3, 8'h10);
    tagReply(2, 1'b0, 8'h40);
    waitRsp(8'h02, 2, 8'h40);
    expInf(3, 8'h10);
    rdCmd(CMD_I, 253, 8'h20);
    tagReply(253, 1'b0, 8'h50);
    waitRsp(8'h03, 253, 8'h50);
    expInf(253, 8'h20);
    rdCmd(CMD_NAK, 0, 8'h00);
    waitRsp(8'ha3, 0, 8'h00);
    rdCmd(CMD_ICHAIN, 61, 8'h30);
    waitRsp(8'ha2, 0, 8'h00);
    expInf(61, 8'h30);
    rdCmd(CMD_I, 2, 8'h60);
    tagReply(1, 1'b0, 8'h70);
    waitRsp(8'h03, 1, 8'h70);
    expInf(2, 8'h60);
    rdCmd(CMD_I, 2, 8'h11);
    tagReply(61, 1'b1, 8'h22);
    waitRsp(8'h12, 61, 8'h22);
    rdCmd(CMD_ACK, 0, 8'h00);
    tagReply(1, 1'b0, 8'h33);
    waitRsp(8'h03, 1, 8'h33);
    rdCmd(CMD_ACK, 0, 8'h00);
    repeat (10) tick;
    chk(16'(rspHit), 16'h0000, "reply to plain ack");
    rdCmd(CMD_NAK, 0, 8'h00);
    waitRsp(8'h03, 1, 8'h33);
    rdCmd(CMD_DESEL, 0, 8'h00);
    waitRsp(8'hc2, 0, 8'h00);
    chk(16'(deselected), 16'h0001, "deselected");
    act;
    rdCmd(CMD_I, 1, 8'h44);
    tagReply(1, 1'b0, 8'h55);
    waitRsp(8'h02, 1, 8'h55);
    expInf(1, 8'h44);
    complete_run;
  end
endmodule
